// ---- rtl/adc_seq_regs.svh ----
// Register offsets, field positions, reset values and timing counts of the converter sequencer.
// Functional notes
// - Ready output rises when power-on settling ends.
// - Modulators wait 300 periods before first samples.
// - Both filter paths run; fast one, three-period sinc.
// - First two results fast path, then sinc path.
// - Default ratio: period 1024, results 1324, 3372.
// - Command or pin reset skips power-on settling.
// - Continuous mode: one result per ratio count.
// - Chop alternates input polarity each conversion.
// - Chop result averages sliding opposite-polarity pair.
// - Filter resets at every polarity swap.
// - Programmable settle delay after each swap.
// - Chop spacing is delay plus three ratios.
// - Ready falls for every new chop result.
// - Chop restarts on sync fall or ratio change.
// - First chop result: two intervals plus 44.
// - DC test signal unavailable while chopping.
// - Chop disables phase calibration delays.
// - Long sync pin low resets until high.
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH

`define CTRL_OFFSET       12'h000
`define COMMAND_OFFSET    12'h004
`define STATUS_OFFSET     12'h008
`define RESULT_OFFSET     12'h00c

`define CTRL_CHOP_BIT     0
`define CTRL_DLY_LSB      4
`define CTRL_OSR_LSB      8
`define CTRL_DC_TEST_BIT  12
`define CTRL_PHASE_BIT    13
`define COMMAND_RESET_BIT 0

`define CHOP_DELAY_CODE_RESET  4'h0
`define OSR_CODE_RESET         3'h3
`define OSR_BASE               128

`define MOD_WAIT_PERIODS  (256 + 44)
`define CHOP_LEAD_PERIODS 44
`define SINC_PERIODS      3
`define FAST_RESULTS      2

`endif

// ---- rtl/adc_seq_pkg.sv ----
// Types shared by the converter sequencer.
package adc_seq_pkg;

  typedef enum logic [2:0] {
    ST_POR,
    ST_PIN_RESET,
    ST_MOD_WAIT,
    ST_CONVERT,
    ST_CHOP_LEAD,
    ST_CHOP_DELAY,
    ST_CHOP_CONVERT
  } seq_state_t;

endpackage : adc_seq_pkg

// ---- rtl/adc_startup_and_chop_sequencer.sv ----
// Start-up, continuous-conversion and chop sequencing with an AXI4-Lite register slave.
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/100ps
`include "adc_seq_regs.svh"

module adc_startup_and_chop_sequencer
  import adc_seq_pkg::*;
#(
  parameter int POR_CYCLES  = 64,
  parameter int RSL_CYCLES  = 2048,
  parameter int CONVERSION_READY_N_CYCLES = 4
) (
  input  wire  logic        CLOCK,
  input  wire  logic        RESET,
  input  wire  logic        CLOCK_ENABLE,
  input  wire  logic        SYNC_RESET_N,
  input  wire  logic [23:0] CONV_DATA,
  input  wire  logic [11:0] AWADDR,
  input  wire  logic        AWVALID,
  output logic              AWREADY,
  input  wire  logic [31:0] WDATA,
  input  wire  logic [3:0]  WSTRB,
  input  wire  logic        WVALID,
  output logic              WREADY,
  output logic [1:0]        BRESP,
  output logic              BVALID,
  input  wire  logic        BREADY,
  input  wire  logic [11:0] ARADDR,
  input  wire  logic        ARVALID,
  output logic              ARREADY,
  output logic [31:0]       RDATA,
  output logic [1:0]        RRESP,
  output logic              RVALID,
  input  wire  logic        RREADY,
  output logic              CONVERSION_READY_N,
  output logic              MOD_RUN,
  output logic              FAST_SELECT,
  output logic              FILTER_RESET,
  output logic              POLARITY_REVERSED,
  output logic              DC_TEST_SELECT,
  output logic              PHASE_CAL_ACTIVE
);
  // ******************************************************************
  // Declarations
  // ******************************************************************
  seq_state_t   state;
  logic [19:0]  cnt;
  logic [19:0]  oversampling_ratio;
  logic [19:0]  chop_settle_delay;
  logic         chop_enable_bit;
  logic [3:0]   chop_settle_delay_code;
  logic [2:0]   osr_code;
  logic [2:0]   osr_code_seen;
  logic         dc_test_req;
  logic         phase_cal_req;
  logic         cmd_reset;
  logic         sync_q;
  logic [11:0]  low_cnt;
  logic         pin_reset;
  logic         sync_fall;
  logic         chop_restart;
  logic         cfg_reset;
  logic         conv_done;
  logic         chop_done;
  logic [1:0]   results_seen;
  logic         pair_ready;
  logic [23:0]  held;
  logic [23:0]  result;
  logic [24:0]  next_sum;
  logic [23:0]  signed_data;
  logic [7:0]   conversion_ready_n_cnt;
  logic         aw_held;
  logic         w_held;
  logic [11:0]  aw_addr;
  logic [31:0]  w_data;
  logic [3:0]   w_strb;
  logic         do_write;
  assign oversampling_ratio = 20'(`OSR_BASE) << osr_code;
  assign chop_settle_delay = 20'h00002 << chop_settle_delay_code;
  assign sync_fall = sync_q && !SYNC_RESET_N;
  assign pin_reset = (low_cnt == 12'(RSL_CYCLES));
  assign cfg_reset = pin_reset || cmd_reset;
  assign chop_restart = sync_fall || (osr_code != osr_code_seen);
  assign conv_done = (state == ST_CONVERT) && (cnt == 20'h00000);
  assign chop_done = (state == ST_CHOP_CONVERT) && (cnt == 20'h00000);
  assign signed_data = POLARITY_REVERSED ? 24'(-CONV_DATA) : CONV_DATA;
  assign next_sum = {held[23], held} + {signed_data[23], signed_data};
  assign do_write = aw_held && w_held && !BVALID;
  // ******************************************************************
  // Sync-or-reset pin
  // ******************************************************************
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      sync_q  <= 1'b1;
      low_cnt <= 12'h000;
    end else if (CLOCK_ENABLE) begin
      sync_q <= SYNC_RESET_N;
      if (SYNC_RESET_N) begin
        low_cnt <= 12'h000;
      end else if (!pin_reset) begin
        low_cnt <= low_cnt + 12'h001;
      end
    end
  end
  // ******************************************************************
  // Sequencer
  // ******************************************************************
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      state <= ST_POR;
      cnt   <= 20'(POR_CYCLES - 1);
    end else if (CLOCK_ENABLE) begin
      if (pin_reset) begin
        state <= ST_PIN_RESET;
      end else if (cmd_reset) begin
        state <= ST_MOD_WAIT;
        cnt   <= 20'(`MOD_WAIT_PERIODS - 1);
      end else if ((state == ST_CONVERT && chop_enable_bit) ||
                   ((state == ST_CHOP_DELAY || state == ST_CHOP_CONVERT) && chop_restart)) begin
        state <= ST_CHOP_LEAD;
        cnt   <= 20'(`CHOP_LEAD_PERIODS - 1);
      end else begin
        case (state)
          ST_POR: begin
            if (cnt == 20'h00000) begin
              state <= ST_MOD_WAIT;
              cnt   <= 20'(`MOD_WAIT_PERIODS - 1);
            end else begin
              cnt <= cnt - 20'h00001;
            end
          end
          ST_PIN_RESET: begin
            if (SYNC_RESET_N) begin
              state <= ST_MOD_WAIT;
              cnt   <= 20'(`MOD_WAIT_PERIODS - 1);
            end
          end
          ST_MOD_WAIT: begin
            if (cnt != 20'h00000) begin
              cnt <= cnt - 20'h00001;
            end else if (chop_enable_bit) begin
              state <= ST_CHOP_LEAD;
              cnt   <= 20'(`CHOP_LEAD_PERIODS - 1);
            end else begin
              state <= ST_CONVERT;
              cnt   <= oversampling_ratio - 20'h00001;
            end
          end
          ST_CONVERT: begin
            if (cnt == 20'h00000) begin
              cnt <= oversampling_ratio - 20'h00001;
            end else begin
              cnt <= cnt - 20'h00001;
            end
          end
          ST_CHOP_LEAD: begin
            if (cnt == 20'h00000) begin
              state <= ST_CHOP_DELAY;
              cnt   <= chop_settle_delay - 20'h00001;
            end else begin
              cnt <= cnt - 20'h00001;
            end
          end
          ST_CHOP_DELAY: begin
            if (cnt == 20'h00000) begin
              state <= ST_CHOP_CONVERT;
              cnt   <= 20'(`SINC_PERIODS * oversampling_ratio - 20'h00001);
            end else begin
              cnt <= cnt - 20'h00001;
            end
          end
          ST_CHOP_CONVERT: begin
            if (cnt != 20'h00000) begin
              cnt <= cnt - 20'h00001;
            end else if (chop_enable_bit) begin
              state <= ST_CHOP_DELAY;
              cnt   <= chop_settle_delay - 20'h00001;
            end else begin
              state <= ST_CONVERT;
              cnt   <= oversampling_ratio - 20'h00001;
            end
          end
          default: begin
            state <= ST_POR;
            cnt   <= 20'(POR_CYCLES - 1);
          end
        endcase
      end
    end
  end
  // ******************************************************************
  // Filter path, polarity and result
  // ******************************************************************
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      MOD_RUN           <= 1'b0;
      FAST_SELECT       <= 1'b1;
      FILTER_RESET      <= 1'b1;
      POLARITY_REVERSED <= 1'b0;
      results_seen      <= 2'h0;
      pair_ready        <= 1'b0;
      held              <= 24'h000000;
      result            <= 24'h000000;
    end else if (CLOCK_ENABLE) begin
      MOD_RUN      <= (state == ST_CONVERT) || (state == ST_CHOP_CONVERT) || (state == ST_CHOP_DELAY);
      FILTER_RESET <= 1'b0;
      if (pin_reset || cmd_reset || state == ST_MOD_WAIT || state == ST_POR) begin
        results_seen      <= 2'h0;
        FAST_SELECT       <= 1'b1;
        FILTER_RESET      <= 1'b1;
        POLARITY_REVERSED <= 1'b0;
      end else if (state == ST_CHOP_LEAD) begin
        POLARITY_REVERSED <= 1'b0;
        FILTER_RESET      <= 1'b1;
        FAST_SELECT       <= 1'b0;
        pair_ready        <= 1'b0;
      end else if (conv_done) begin
        result <= CONV_DATA;
        results_seen <= results_seen + {1'b0, results_seen != 2'(`FAST_RESULTS)};
        FAST_SELECT <= (results_seen + 2'h1) < 2'(`FAST_RESULTS);
      end else if (chop_done) begin
        held              <= signed_data;
        pair_ready        <= 1'b1;
        POLARITY_REVERSED <= !POLARITY_REVERSED;
        FILTER_RESET      <= 1'b1;
        if (pair_ready) begin
          result <= next_sum[24:1];
        end
      end
    end
  end
  // ******************************************************************
  // Ready output
  // ******************************************************************
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      CONVERSION_READY_N <= 1'b0;
      conversion_ready_n_cnt           <= 8'h00;
    end else if (CLOCK_ENABLE) begin
      if (state == ST_POR || state == ST_PIN_RESET) begin
        CONVERSION_READY_N <= 1'b0;
      end else if (conv_done || (chop_done && pair_ready)) begin
        CONVERSION_READY_N <= 1'b0;
        conversion_ready_n_cnt           <= 8'(CONVERSION_READY_N_CYCLES - 1);
      end else if (conversion_ready_n_cnt != 8'h00) begin
        conversion_ready_n_cnt <= conversion_ready_n_cnt - 8'h01;
      end else begin
        CONVERSION_READY_N <= 1'b1;
      end
    end
  end
  // ******************************************************************
  // Configuration
  // ******************************************************************
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      chop_enable_bit        <= 1'b0;
      chop_settle_delay_code <= `CHOP_DELAY_CODE_RESET;
      osr_code               <= `OSR_CODE_RESET;
      osr_code_seen          <= `OSR_CODE_RESET;
      dc_test_req            <= 1'b0;
      phase_cal_req          <= 1'b0;
      cmd_reset              <= 1'b0;
      DC_TEST_SELECT         <= 1'b0;
      PHASE_CAL_ACTIVE       <= 1'b0;
    end else if (CLOCK_ENABLE) begin
      cmd_reset     <= 1'b0;
      osr_code_seen <= osr_code;
      DC_TEST_SELECT   <= dc_test_req && !chop_enable_bit;
      PHASE_CAL_ACTIVE <= phase_cal_req && !chop_enable_bit;
      if (cfg_reset) begin
        chop_enable_bit        <= 1'b0;
        chop_settle_delay_code <= `CHOP_DELAY_CODE_RESET;
        osr_code               <= `OSR_CODE_RESET;
        osr_code_seen          <= `OSR_CODE_RESET;
        dc_test_req            <= 1'b0;
        phase_cal_req          <= 1'b0;
      end else if (do_write && aw_addr == `CTRL_OFFSET) begin
        if (w_strb[0]) begin
          chop_enable_bit        <= w_data[`CTRL_CHOP_BIT];
          chop_settle_delay_code <= w_data[`CTRL_DLY_LSB +: 4];
        end
        if (w_strb[1]) begin
          osr_code      <= w_data[`CTRL_OSR_LSB +: 3];
          dc_test_req   <= w_data[`CTRL_DC_TEST_BIT];
          phase_cal_req <= w_data[`CTRL_PHASE_BIT];
        end
      end else if (do_write && aw_addr == `COMMAND_OFFSET && w_strb[0]) begin
        cmd_reset <= w_data[`COMMAND_RESET_BIT];
      end
    end
  end
  // ******************************************************************
  // AXI4-Lite write channel
  // ******************************************************************
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      AWREADY <= 1'b0;
      WREADY  <= 1'b0;
      BVALID  <= 1'b0;
      BRESP   <= 2'h0;
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 12'h000;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
    end else if (CLOCK_ENABLE) begin
      AWREADY <= !aw_held && !AWREADY && AWVALID;
      WREADY  <= !w_held && !WREADY && WVALID;
      if (AWVALID && AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_held <= 1'b1;
        w_data <= WDATA;
        w_strb <= WSTRB;
      end
      if (do_write) begin
        BVALID  <= 1'b1;
        BRESP   <= (aw_addr == `CTRL_OFFSET || aw_addr == `COMMAND_OFFSET) ? 2'h0 : 2'h2;
        aw_held <= 1'b0;
        w_held  <= 1'b0;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end
  // ******************************************************************
  // AXI4-Lite read channel
  // ******************************************************************
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= 32'h00000000;
      RRESP   <= 2'h0;
    end else if (CLOCK_ENABLE) begin
      ARREADY <= !ARREADY && !RVALID && ARVALID;
      if (ARVALID && ARREADY) begin
        RVALID <= 1'b1;
        RRESP  <= 2'h0;
        case (ARADDR)
          `CTRL_OFFSET: begin
            RDATA <= {18'h00000, phase_cal_req, dc_test_req, 1'b0, osr_code,
                      chop_settle_delay_code, 3'h0, chop_enable_bit};
          end
          `COMMAND_OFFSET: begin
            RDATA <= 32'h00000000;
          end
          `STATUS_OFFSET: begin
            RDATA <= {25'h0000000, CONVERSION_READY_N, POLARITY_REVERSED, FAST_SELECT, 1'b0, state};
          end
          `RESULT_OFFSET: begin
            RDATA <= {{8{result[23]}}, result};
          end
          default: begin
            RDATA <= 32'h00000000;
            RRESP <= 2'h2;
          end
        endcase
      end else if (RVALID && RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end

endmodule : adc_startup_and_chop_sequencer

// ---- dv/adc_seq_chk.sv ----
// Port assertions for the converter sequencer.
`timescale 1ns/100ps
module adc_seq_chk #(
  parameter int CONVERSION_READY_N_CYCLES = 4
) (
  input wire logic        CLOCK,
  input wire logic        RESET,
  input wire logic        SYNC_RESET_N,
  input wire logic [11:0] AWADDR,
  input wire logic        AWVALID,
  input wire logic        AWREADY,
  input wire logic [1:0]  BRESP,
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic        CONVERSION_READY_N,
  input wire logic        MOD_RUN,
  input wire logic        FAST_SELECT,
  input wire logic        FILTER_RESET,
  input wire logic        POLARITY_REVERSED,
  input wire logic        DC_TEST_SELECT,
  input wire logic        PHASE_CAL_ACTIVE
);
  int low_cnt;
  int idle;
  default clocking @(posedge CLOCK);
  endclocking
  default disable iff (RESET);
  // Idle counts modulator-off cycles with ready high, i.e. the start-up wait or chop lead.
  always_ff @(posedge CLOCK) begin
    if (RESET || CONVERSION_READY_N)
      low_cnt <= 0;
    else
      low_cnt <= low_cnt + 1;
  end
  always_ff @(posedge CLOCK) begin
    if (RESET || MOD_RUN || !CONVERSION_READY_N)
      idle <= 0;
    else
      idle <= idle + 1;
  end
  ready_pulse_a: assert property ($rose(CONVERSION_READY_N) && MOD_RUN |-> low_cnt == CONVERSION_READY_N_CYCLES)
    else $error("ready pulse width wrong");
  result_run_a: assert property ($fell(CONVERSION_READY_N) && SYNC_RESET_N |-> $past(MOD_RUN))
    else $error("result without running modulators");
  mod_wait_a: assert property ($rose(MOD_RUN) |-> idle inside {[43:45], [299:301]})
    else $error("modulator wait length wrong");
  fast_restart_a: assert property ($rose(FAST_SELECT) |-> ##[0:1] !MOD_RUN)
    else $error("fast path reselected while running");
  swap_reset_a: assert property ($changed(POLARITY_REVERSED) && $past(MOD_RUN) |-> FILTER_RESET || $past(FILTER_RESET))
    else $error("polarity swap without filter reset");
  chop_off_a: assert property (POLARITY_REVERSED |-> !DC_TEST_SELECT && !PHASE_CAL_ACTIVE)
    else $error("test signal or phase cal active in chop");
  b_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped early");
  bad_addr_a: assert property (AWVALID && AWREADY && AWADDR > 12'h00c |-> ##[1:8] BVALID && BRESP == 2'h2)
    else $error("unmapped write not refused");
  cover property ($fell(CONVERSION_READY_N) && !FAST_SELECT);
  cover property ($changed(POLARITY_REVERSED));
  cover property (BVALID && BRESP == 2'h2);
endmodule : adc_seq_chk

bind adc_startup_and_chop_sequencer adc_seq_chk #(.CONVERSION_READY_N_CYCLES(CONVERSION_READY_N_CYCLES)) u_adc_seq_chk (
  .CLOCK(CLOCK), .RESET(RESET), .SYNC_RESET_N(SYNC_RESET_N), .AWADDR(AWADDR), .AWVALID(AWVALID),
  .AWREADY(AWREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .CONVERSION_READY_N(CONVERSION_READY_N),
  .MOD_RUN(MOD_RUN), .FAST_SELECT(FAST_SELECT), .FILTER_RESET(FILTER_RESET),
  .POLARITY_REVERSED(POLARITY_REVERSED), .DC_TEST_SELECT(DC_TEST_SELECT), .PHASE_CAL_ACTIVE(PHASE_CAL_ACTIVE));

// ---- dv/adc_filter_model.sv ----
// Filter-path model feeding a steady input level through the chop switches.
`timescale 1ns/100ps
module adc_filter_model (
  input wire logic        clock,
  input wire logic        polarity_reversed,
  input wire logic [23:0] level,
  output logic     [23:0] conv_data
);
  always_ff @(posedge clock) begin
    conv_data <= polarity_reversed ? -level : level;
  end
endmodule : adc_filter_model

// ---- dv/adc_startup_and_chop_sequencer_bench.sv ----
// Self-checking bench for the start-up and chop sequencer.
`timescale 1ns/100ps
`include "adc_seq_regs.svh"
module adc_startup_and_chop_sequencer_bench;
  import adc_seq_pkg::*;
  typedef struct {int gap; int tol; logic fast;} note_t;
  logic        clock = 1'b0, reset = 1'b1, sync_n = 1'b1;
  logic [23:0] level = 24'h0, conv;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, rdy_n, mod_run, fast, frst, pol, dct, pca;
  logic [1:0]  bresp, rresp;
  note_t       q[$];
  logic [33:0] bq[$];
  int          mismatches = 0, n_checks = 0, cyc = 0, mark = 0, k, d;
  logic        prv = 1'b0, prv_fast = 1'b0;
  logic [31:0] dflt;

  initial begin
    forever #50 clock = ~clock;
  end

  adc_startup_and_chop_sequencer #(.POR_CYCLES(8), .RSL_CYCLES(16)) u_adc_startup_and_chop_sequencer (
    .CLOCK(clock), .RESET(reset), .CLOCK_ENABLE(1'b1), .SYNC_RESET_N(sync_n), .CONV_DATA(conv),
    .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid),
    .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .CONVERSION_READY_N(rdy_n), .MOD_RUN(mod_run), .FAST_SELECT(fast), .FILTER_RESET(frst),
    .POLARITY_REVERSED(pol), .DC_TEST_SELECT(dct), .PHASE_CAL_ACTIVE(pca));

  adc_filter_model u_adc_filter_model (.clock(clock), .polarity_reversed(pol), .level(level), .conv_data(conv));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  task automatic chk_val(input string what, input logic [33:0] exp, input logic [33:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_val

  // A fast value of x leaves the path unchecked.
  task automatic chk_gap(input note_t e, input int got, input logic f);
    n_checks++;
    if (got < e.gap - e.tol || got > e.gap + e.tol || (e.fast !== 1'bx && f !== e.fast)) begin
      mismatches++;
      $display("ERROR result spacing/fast expected %0d/%b seen %0d/%b", e.gap, e.fast, got, f);
    end
  endtask : chk_gap

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      give_verdict();
    end
    if (bvalid && bready)
      chk_val("write response", bq.pop_front(), {bresp, 32'h0});
    if (rvalid && rready)
      chk_val("read data", bq.pop_front(), {rresp, rdata});
    if (prv && !rdy_n && !reset && q.size() > 0)
      chk_gap(q.pop_front(), cyc - mark, prv_fast);
    if (prv && !rdy_n)
      mark = cyc;
    prv <= rdy_n;
    prv_fast <= fast;
  end

  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] r);
    logic pa, pw;
    @(posedge clock);
    bq.push_back({r, 32'h0});
    pa = 1'b1;
    pw = 1'b1;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (pa || pw) begin
      @(posedge clock);
      pa = pa && awready !== 1'b1;
      pw = pw && wready !== 1'b1;
      awvalid <= pa;
      wvalid <= pw;
    end
    do @(posedge clock); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    @(posedge clock);
    bq.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clock); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask : rd

  task automatic drain;
    while (q.size() > 0)
      @(posedge clock);
  endtask : drain

  // Start-up after any reset: two fast-path results, then one sinc result at the default ratio.
  task automatic start3(input int tol);
    mark = cyc;
    q.push_back('{`MOD_WAIT_PERIODS + 1024, tol, 1'b1});
    q.push_back('{1024, 0, 1'b1});
    q.push_back('{1024, 0, 1'b0});
  endtask : start3

  initial begin
    void'($urandom(32'h95f6));
    level = 24'($urandom());
    k = $urandom_range(5, 0);
    d = 2 << k;
    dflt = 32'(`OSR_CODE_RESET) << `CTRL_OSR_LSB;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    while (rdy_n !== 1'b1)
      @(posedge clock);
    start3(3);
    drain();
    rd(`CTRL_OFFSET, {2'h0, dflt});
    rd(12'h010, {2'h2, 32'h0});
    wr(12'h010, 32'h1, 2'h2);
    wr(`CTRL_OFFSET, 32'h3000, 2'h0);
    repeat (2) @(posedge clock);
    chk_val("dc test select", 34'h1, {33'h0, dct});
    chk_val("phase cal active", 34'h1, {33'h0, pca});
    q.push_back('{0, 100000, 1'b0});
    q.push_back('{128, 0, 1'b0});
    drain();
    rd(`RESULT_OFFSET, {2'h0, {8{level[23]}}, level});
    wr(`CTRL_OFFSET, 32'h3001 | (k << `CTRL_DLY_LSB), 2'h0);
    mark = cyc;
    q.push_back('{44 + 2 * (d + 384), 6, 1'b0});
    q.push_back('{d + 384, 0, 1'bx});
    q.push_back('{d + 384, 0, 1'bx});
    drain();
    chk_val("dc test select", 34'h0, {33'h0, dct});
    chk_val("phase cal active", 34'h0, {33'h0, pca});
    rd(`RESULT_OFFSET, {2'h0, {8{level[23]}}, level});
    sync_n <= 1'b0;
    mark = cyc;
    repeat (3) @(posedge clock);
    sync_n <= 1'b1;
    q.push_back('{44 + 2 * (d + 384), 6, 1'b0});
    q.push_back('{d + 384, 0, 1'bx});
    drain();
    wr(`CTRL_OFFSET, 32'h3101 | (k << `CTRL_DLY_LSB), 2'h0);
    mark = cyc;
    q.push_back('{44 + 2 * (d + 768), 6, 1'bx});
    drain();
    repeat (10) @(posedge clock);
    wr(`COMMAND_OFFSET, 32'h1, 2'h0);
    start3(6);
    drain();
    rd(`CTRL_OFFSET, {2'h0, dflt});
    repeat (10) @(posedge clock);
    sync_n <= 1'b0;
    repeat (20) @(posedge clock);
    chk_val("ready in pin reset", 34'h0, {33'h0, rdy_n});
    sync_n <= 1'b1;
    start3(6);
    drain();
    give_verdict();
  end
endmodule : adc_startup_and_chop_sequencer_bench
